/* common/ram_pointer_pkg.sv */
// types for the ram pointer transfer unit
package ram_pointer_pkg;
  typedef enum logic [3:0] {
    OP_D_TO_ACC,
    OP_Z_TO_ACC,
    OP_X_TO_ACC,
    OP_SP_TO_ACC,
    OP_POINTER_PAIR_LOAD,
    OP_Z_LOAD,
    OP_Y_INC,
    OP_Y_DEC,
    OP_RAM_TO_ACC,
    OP_RAM_EXCHANGE,
    OP_RAM_EXCHANGE_DEC,
    OP_RAM_EXCHANGE_INC,
    OP_ACC_TO_RAM
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RAM_WAIT
  } state_t;
endpackage

/* common/ram_pointer_regs.svh */
// constants for the ram pointer transfer unit
`ifndef RAM_POINTER_REGS_SVH
`define RAM_POINTER_REGS_SVH
`define RPT_NIB_W      4
`define RPT_Z_W        2
`define RPT_D_W        3
`define RPT_SP_W       3
`define RPT_ADDR_W     10
`define RPT_Y_INC_WRAP 4'h0
`define RPT_Y_DEC_WRAP 4'hf
`define RPT_NIB_ONE    4'h1
`define RPT_NIB_ZERO   4'h0
`define RPT_Z_ZERO     2'h0
`endif

/* core/ram_nibble_mem.sv */
// nibble memory with registered read data
module ram_nibble_mem #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 4
) (
  // clock
  input  wire logic              clk_sys_i,
  // write port
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_reg[rd_addr_i];
  end
endmodule // ram_nibble_mem

/* core/ram_pointer_transfer_ops.sv */
// register transfer and ram addressing execution unit
//
// Behaviour
// - D copied into accumulator bits 2..0
// - Z copied into accumulator bits 1..0
// - X copied into whole accumulator
// - return stack index into accumulator bits 2..0
// - pointer pair load writes X and Y
// - consecutive pointer pair loads: only first executes
// - Z load writes immediate into Z
// - Y increment, skip next when Y becomes 0
// - Y decrement, skip next when Y becomes 15
// - ram to accumulator, then X xor j
// - exchange accumulator with ram, then X xor j
// - exchange, X xor j, decrement Y, skip on 15
// - exchange, X xor j, increment Y, skip on 0
// - accumulator to ram, then X xor j
`include "ram_pointer_regs.svh"
module ram_pointer_transfer_ops
  import ram_pointer_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  // decoded instruction
  input  wire logic                    op_valid_i,
  input  wire op_t                     op_i,
  input  wire logic [`RPT_NIB_W-1:0]   imm_a_i,
  input  wire logic [`RPT_NIB_W-1:0]   imm_b_i,
  // core registers read by transfers
  input  wire logic [`RPT_D_W-1:0]     d_i,
  input  wire logic [`RPT_SP_W-1:0]    return_stack_index_i,
  // state
  output logic                         busy_o,
  output logic                         skip_o,
  output logic [`RPT_NIB_W-1:0]        acc_o,
  output logic [`RPT_NIB_W-1:0]        x_o,
  output logic [`RPT_NIB_W-1:0]        y_o,
  output logic [`RPT_Z_W-1:0]          z_o
);
  // ***************************************************************
  // state
  // ***************************************************************
  state_t                  state_reg, state_next;
  op_t                     op_reg, op_next;
  logic [`RPT_NIB_W-1:0]   acc_reg, acc_next;
  logic [`RPT_NIB_W-1:0]   x_reg, x_next;
  logic [`RPT_NIB_W-1:0]   y_reg, y_next;
  logic [`RPT_Z_W-1:0]     z_reg, z_next;
  logic [`RPT_NIB_W-1:0]   j_reg, j_next;
  logic [`RPT_ADDR_W-1:0]  addr_reg, addr_next;
  logic                    skip_reg, skip_next;
  logic                    last_load_reg, last_load_next;
  logic                    busy_reg, busy_next;
  logic                    take;
  logic                    do_skip;
  logic                    exec;
  logic                    wr_en;
  logic [`RPT_NIB_W-1:0]   ram_rd;
  logic [`RPT_ADDR_W-1:0]  ram_data_pointer;

  assign ram_data_pointer = {z_reg, x_reg, y_reg};
  assign take    = op_valid_i && (state_reg == ST_IDLE);
  assign do_skip = skip_reg || (op_i == OP_POINTER_PAIR_LOAD && last_load_reg);
  assign exec    = take && !do_skip;

  // ***************************************************************
  // addressed ram nibble storage
  // ***************************************************************
  ram_nibble_mem #(
    .ADDR_W (`RPT_ADDR_W),
    .DATA_W (`RPT_NIB_W)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .wr_en_i   (wr_en),
    .wr_addr_i (addr_reg),
    .wr_data_i (acc_reg),
    .rd_addr_i (ram_data_pointer),
    .rd_data_o (ram_rd)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    state_next     = state_reg;
    op_next        = op_reg;
    acc_next       = acc_reg;
    x_next         = x_reg;
    y_next         = y_reg;
    z_next         = z_reg;
    j_next         = j_reg;
    addr_next      = addr_reg;
    skip_next      = skip_reg;
    last_load_next = last_load_reg;
    wr_en          = 1'b0;
    if (take)
    begin
      skip_next      = 1'b0;
      last_load_next = (op_i == OP_POINTER_PAIR_LOAD);
    end
    if (exec)
    begin
      case (op_i)
        OP_D_TO_ACC:          acc_next[`RPT_D_W-1:0] = d_i;
        OP_Z_TO_ACC:          acc_next[`RPT_Z_W-1:0] = z_reg;
        OP_X_TO_ACC:          acc_next = x_reg;
        OP_SP_TO_ACC:         acc_next[`RPT_SP_W-1:0] = return_stack_index_i;
        OP_POINTER_PAIR_LOAD:
        begin
          x_next = imm_a_i;
          y_next = imm_b_i;
        end
        OP_Z_LOAD:            z_next = imm_a_i[`RPT_Z_W-1:0];
        OP_Y_INC:
        begin
          y_next    = y_reg + `RPT_NIB_ONE;
          skip_next = (y_next == `RPT_Y_INC_WRAP);
        end
        OP_Y_DEC:
        begin
          y_next    = y_reg - `RPT_NIB_ONE;
          skip_next = (y_next == `RPT_Y_DEC_WRAP);
        end
        default:
        begin
          // ram operations finish once the read data is registered
          state_next = ST_RAM_WAIT;
          op_next    = op_i;
          j_next     = imm_a_i;
          addr_next  = ram_data_pointer;
        end
      endcase
    end
    if (state_reg == ST_RAM_WAIT)
    begin
      state_next = ST_IDLE;
      x_next     = x_reg ^ j_reg;
      case (op_reg)
        OP_RAM_TO_ACC:        acc_next = ram_rd;
        OP_ACC_TO_RAM:        wr_en = 1'b1;
        OP_RAM_EXCHANGE:
        begin
          acc_next = ram_rd;
          wr_en    = 1'b1;
        end
        OP_RAM_EXCHANGE_DEC:
        begin
          acc_next  = ram_rd;
          wr_en     = 1'b1;
          y_next    = y_reg - `RPT_NIB_ONE;
          skip_next = (y_next == `RPT_Y_DEC_WRAP);
        end
        OP_RAM_EXCHANGE_INC:
        begin
          acc_next  = ram_rd;
          wr_en     = 1'b1;
          y_next    = y_reg + `RPT_NIB_ONE;
          skip_next = (y_next == `RPT_Y_INC_WRAP);
        end
        default:              x_next = x_reg;
      endcase
    end
    busy_next = (state_next != ST_IDLE);
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg     <= ST_IDLE;
      op_reg        <= OP_D_TO_ACC;
      acc_reg       <= `RPT_NIB_ZERO;
      x_reg         <= `RPT_NIB_ZERO;
      y_reg         <= `RPT_NIB_ZERO;
      z_reg         <= `RPT_Z_ZERO;
      j_reg         <= `RPT_NIB_ZERO;
      addr_reg      <= '0;
      skip_reg      <= 1'b0;
      last_load_reg <= 1'b0;
      busy_reg      <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      op_reg        <= op_next;
      acc_reg       <= acc_next;
      x_reg         <= x_next;
      y_reg         <= y_next;
      z_reg         <= z_next;
      j_reg         <= j_next;
      addr_reg      <= addr_next;
      skip_reg      <= skip_next;
      last_load_reg <= last_load_next;
      busy_reg      <= busy_next;
    end
  end

  assign busy_o = busy_reg;
  assign skip_o = skip_reg;
  assign acc_o  = acc_reg;
  assign x_o    = x_reg;
  assign y_o    = y_reg;
  assign z_o    = z_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_exec(op_t o);
    exec && op_i == o;
  endsequence

  property p_d_to_acc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_D_TO_ACC) |=> acc_reg == {$past(acc_reg[3]), $past(d_i)};
  endproperty
  a_d_to_acc: assert property (p_d_to_acc) else $error("d transfer wrong");

  property p_z_to_acc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_Z_TO_ACC) |=> acc_reg[1:0] == $past(z_reg) && acc_reg[3:2] == $past(acc_reg[3:2]);
  endproperty
  a_z_to_acc: assert property (p_z_to_acc) else $error("z transfer wrong");

  property p_x_to_acc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_X_TO_ACC) |=> acc_reg == $past(x_reg);
  endproperty
  a_x_to_acc: assert property (p_x_to_acc) else $error("x transfer wrong");

  property p_sp_to_acc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_SP_TO_ACC) |=> acc_reg[2:0] == $past(return_stack_index_i);
  endproperty
  a_sp_to_acc: assert property (p_sp_to_acc) else $error("stack index transfer wrong");

  property p_pair_load;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_POINTER_PAIR_LOAD) |=> x_reg == $past(imm_a_i) && y_reg == $past(imm_b_i) && !skip_reg;
  endproperty
  a_pair_load: assert property (p_pair_load) else $error("pointer pair load wrong");

  property p_pair_chain;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    take && op_i == OP_POINTER_PAIR_LOAD ##1 take && op_i == OP_POINTER_PAIR_LOAD
      |=> $stable(x_reg) && $stable(y_reg);
  endproperty
  a_pair_chain: assert property (p_pair_chain) else $error("chained pair load executed");

  property p_z_load;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_Z_LOAD) |=> z_reg == $past(imm_a_i[1:0]);
  endproperty
  a_z_load: assert property (p_z_load) else $error("z load wrong");

  property p_y_inc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_Y_INC) |=> y_reg == $past(y_reg) + 4'h1 && skip_reg == (y_reg == 4'h0);
  endproperty
  a_y_inc: assert property (p_y_inc) else $error("y increment wrong");

  property p_y_dec;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_Y_DEC) |=> y_reg == $past(y_reg) - 4'h1 && skip_reg == (y_reg == 4'hf);
  endproperty
  a_y_dec: assert property (p_y_dec) else $error("y decrement wrong");

  property p_ram_x;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    exec && (op_i inside {OP_RAM_TO_ACC, OP_RAM_EXCHANGE, OP_ACC_TO_RAM})
      |=> busy_reg ##1 !busy_reg && x_reg == ($past(x_reg, 2) ^ $past(imm_a_i, 2)) && !skip_reg;
  endproperty
  a_ram_x: assert property (p_ram_x) else $error("ram op x update wrong");

  property p_xchg_dec;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_RAM_EXCHANGE_DEC) |=> ##1 y_reg == $past(y_reg, 2) - 4'h1 && skip_reg == (y_reg == 4'hf);
  endproperty
  a_xchg_dec: assert property (p_xchg_dec) else $error("exchange decrement wrong");

  property p_xchg_inc;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec(OP_RAM_EXCHANGE_INC) |=> ##1 y_reg == $past(y_reg, 2) + 4'h1 && skip_reg == (y_reg == 4'h0);
  endproperty
  a_xchg_inc: assert property (p_xchg_inc) else $error("exchange increment wrong");

  property p_skipped;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    take && skip_reg |=> $stable(acc_reg) && $stable(x_reg) && $stable(y_reg) && $stable(z_reg)
      && !busy_reg && !skip_reg;
  endproperty
  a_skipped: assert property (p_skipped) else $error("skipped op changed state");
endmodule // ram_pointer_transfer_ops

/* tb/ram_pointer_transfer_ops_tb.sv */
// self-checking bench for the ram pointer transfer unit
module ram_pointer_transfer_ops_tb
  import ram_pointer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    op_t        op;
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] acc;
    logic [3:0] x;
    logic [3:0] y;
    logic [1:0] z;
    logic       sk;
  } row_t;

  logic       clk_sys_i            = 1'b0;
  logic       rst_n_i              = 1'b0;
  logic       op_valid_i           = 1'b0;
  op_t        op_i                 = OP_D_TO_ACC;
  logic [3:0] imm_a_i              = 4'h0;
  logic [3:0] imm_b_i              = 4'h0;
  logic [2:0] d_i                  = 3'h5;
  logic [2:0] return_stack_index_i = 3'h6;
  logic       busy_o;
  logic       skip_o;
  logic [3:0] acc_o;
  logic [3:0] x_o;
  logic [3:0] y_o;
  logic [1:0] z_o;
  int         num_errors           = 0;
  int         checked              = 0;
  int         cycles               = 0;
  row_t       rows [29];

  always #10 clk_sys_i = ~clk_sys_i;

  ram_pointer_transfer_ops i_dut (
    .clk_sys_i            (clk_sys_i),
    .rst_n_i              (rst_n_i),
    .op_valid_i           (op_valid_i),
    .op_i                 (op_i),
    .imm_a_i              (imm_a_i),
    .imm_b_i              (imm_b_i),
    .d_i                  (d_i),
    .return_stack_index_i (return_stack_index_i),
    .busy_o               (busy_o),
    .skip_o               (skip_o),
    .acc_o                (acc_o),
    .x_o                  (x_o),
    .y_o                  (y_o),
    .z_o                  (z_o)
  );

  // ************************************************************
  // checking and driving tasks
  // ************************************************************
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_all(input logic [3:0] acc, x, y, input logic [1:0] z, input logic sk);
    chk(acc_o, acc);
    chk(x_o, x);
    chk(y_o, y);
    chk({2'h0, z_o}, {2'h0, z});
    chk({3'h0, skip_o}, {3'h0, sk});
  endtask

  // one instruction, caller sits at a rising edge; returns at a rising edge
  task automatic issue(input op_t op, input logic [3:0] a, input logic [3:0] b);
    logic ram;
    op_valid_i <= 1'b1;
    op_i <= op;
    imm_a_i <= a;
    imm_b_i <= b;
    // skip flag is read away from the edge that launches it
    @(negedge clk_sys_i);
    ram = (op >= OP_RAM_TO_ACC) && (skip_o !== 1'b1);
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    if (ram)
    begin
      @(negedge clk_sys_i);
      chk({3'h0, busy_o}, 4'h1);
      @(posedge clk_sys_i);
    end
  endtask

  task automatic conclude;
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    rows = '{
      '{OP_Z_LOAD,           4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 2'h3, 1'b0},
      '{OP_Z_TO_ACC,         4'h0, 4'h0, 4'h3, 4'h0, 4'h0, 2'h3, 1'b0},
      '{OP_D_TO_ACC,         4'h0, 4'h0, 4'h5, 4'h0, 4'h0, 2'h3, 1'b0},
      '{OP_SP_TO_ACC,        4'h0, 4'h0, 4'h6, 4'h0, 4'h0, 2'h3, 1'b0},
      '{OP_POINTER_PAIR_LOAD, 4'h9, 4'he, 4'h6, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_POINTER_PAIR_LOAD, 4'h1, 4'h1, 4'h6, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_X_TO_ACC,         4'h0, 4'h0, 4'h9, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_Y_INC,            4'h0, 4'h0, 4'h9, 4'h9, 4'hf, 2'h3, 1'b0},
      '{OP_Y_INC,            4'h0, 4'h0, 4'h9, 4'h9, 4'h0, 2'h3, 1'b1},
      '{OP_Z_LOAD,           4'h0, 4'h0, 4'h9, 4'h9, 4'h0, 2'h3, 1'b0},
      '{OP_Y_DEC,            4'h0, 4'h0, 4'h9, 4'h9, 4'hf, 2'h3, 1'b1},
      '{OP_Z_TO_ACC,         4'h0, 4'h0, 4'h9, 4'h9, 4'hf, 2'h3, 1'b0},
      '{OP_Y_DEC,            4'h0, 4'h0, 4'h9, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_ACC_TO_RAM,       4'h6, 4'h0, 4'h9, 4'hf, 4'he, 2'h3, 1'b0},
      '{OP_POINTER_PAIR_LOAD, 4'h9, 4'he, 4'h9, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_SP_TO_ACC,        4'h0, 4'h0, 4'he, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_RAM_EXCHANGE,     4'h0, 4'h0, 4'h9, 4'h9, 4'he, 2'h3, 1'b0},
      '{OP_RAM_TO_ACC,       4'h3, 4'h0, 4'he, 4'ha, 4'he, 2'h3, 1'b0},
      '{OP_POINTER_PAIR_LOAD, 4'ha, 4'hf, 4'he, 4'ha, 4'hf, 2'h3, 1'b0},
      '{OP_ACC_TO_RAM,       4'h0, 4'h0, 4'he, 4'ha, 4'hf, 2'h3, 1'b0},
      '{OP_D_TO_ACC,         4'h0, 4'h0, 4'hd, 4'ha, 4'hf, 2'h3, 1'b0},
      '{OP_RAM_EXCHANGE_INC, 4'h0, 4'h0, 4'he, 4'ha, 4'h0, 2'h3, 1'b1},
      '{OP_X_TO_ACC,         4'h0, 4'h0, 4'he, 4'ha, 4'h0, 2'h3, 1'b0},
      '{OP_ACC_TO_RAM,       4'h0, 4'h0, 4'he, 4'ha, 4'h0, 2'h3, 1'b0},
      '{OP_Z_TO_ACC,         4'h0, 4'h0, 4'hf, 4'ha, 4'h0, 2'h3, 1'b0},
      '{OP_RAM_EXCHANGE_DEC, 4'h5, 4'h0, 4'he, 4'hf, 4'hf, 2'h3, 1'b1},
      '{OP_POINTER_PAIR_LOAD, 4'h1, 4'h2, 4'he, 4'hf, 4'hf, 2'h3, 1'b0},
      '{OP_POINTER_PAIR_LOAD, 4'h3, 4'h4, 4'he, 4'hf, 4'hf, 2'h3, 1'b0},
      '{OP_Z_LOAD,           4'h1, 4'h0, 4'he, 4'hf, 4'hf, 2'h1, 1'b0}
    };
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge clk_sys_i);
      issue(rows[i].op, rows[i].a, rows[i].b);
      @(negedge clk_sys_i);
      chk_all(rows[i].acc, rows[i].x, rows[i].y, rows[i].z, rows[i].sk);
    end
    // back-to-back pair loads with no idle cycle between
    @(posedge clk_sys_i);
    op_valid_i <= 1'b1;
    op_i <= OP_POINTER_PAIR_LOAD;
    imm_a_i <= 4'h2;
    imm_b_i <= 4'h3;
    @(posedge clk_sys_i);
    imm_a_i <= 4'h4;
    imm_b_i <= 4'h5;
    @(posedge clk_sys_i);
    issue(OP_Y_INC, 4'h0, 4'h0);
    @(negedge clk_sys_i);
    chk_all(4'he, 4'h2, 4'h4, 2'h1, 1'b0);
    // an instruction offered while the ram access is busy is ignored
    @(posedge clk_sys_i);
    op_valid_i <= 1'b1;
    op_i <= OP_ACC_TO_RAM;
    imm_a_i <= 4'h0;
    @(posedge clk_sys_i);
    op_i <= OP_Z_LOAD;
    imm_a_i <= 4'h2;
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({2'h0, z_o}, 4'h1);
    chk({3'h0, busy_o}, 4'h0);
    // reset in mid-run, then a skipped ram instruction
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    @(negedge clk_sys_i);
    chk_all(4'h0, 4'h0, 4'h0, 2'h0, 1'b0);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    issue(OP_Y_DEC, 4'h0, 4'h0);
    @(posedge clk_sys_i);
    issue(OP_RAM_TO_ACC, 4'h7, 4'h0);
    @(negedge clk_sys_i);
    chk({3'h0, busy_o}, 4'h0);
    chk_all(4'h0, 4'h0, 4'hf, 2'h0, 1'b0);
    // other values on the core register inputs
    @(posedge clk_sys_i);
    d_i                  <= 3'h2;
    return_stack_index_i <= 3'h1;
    issue(OP_D_TO_ACC, 4'h0, 4'h0);
    @(negedge clk_sys_i);
    chk(acc_o, 4'h2);
    @(posedge clk_sys_i);
    issue(OP_SP_TO_ACC, 4'h0, 4'h0);
    @(negedge clk_sys_i);
    chk(acc_o, 4'h1);
    conclude();
  end
endmodule // ram_pointer_transfer_ops_tb
